/* File: rtl/dsh_defines.svh */
// Offsets, field positions, reset values and counts of the deep sleep hold block
`ifndef DSH_DEFINES_SVH
`define DSH_DEFINES_SVH
`define DSH_OFF_CTRL 8'h00
`define DSH_OFF_RST 8'h04
`define DSH_OFF_SCR0 8'h08
`define DSH_OFF_SCR1 8'h0c
`define DSH_OFF_WAKE 8'h10
`define DSH_OFF_DIR 8'h14
`define DSH_OFF_LAT 8'h18
`define DSH_OFF_OSC 8'h1c
`define DSH_OFF_STAT 8'h20
`define DSH_CTRL_ARM 15
`define DSH_CTRL_BOR 1
`define DSH_CTRL_FREEZE 0
`define DSH_RST_EXIT 10
`define DSH_RST_POR 0
`define DSH_OSC_SECONDARY_OSC_EN 1
`define DSH_CW4_WDT_EN 7
`define DSH_CW4_BOR_EN 6
`define DSH_CW4_RTC_SEL 5
`define DSH_CW4_WDT_SEL 4
`define DSH_WAKE_EXTERNAL_INT_ZERO 8
`define DSH_WAKE_FLT 7
`define DSH_WAKE_WDT 4
`define DSH_WAKE_RTC 3
`define DSH_WAKE_MASTER_CLEAR_PIN 2
`define DSH_WAKE_POR 0
`define DSH_WAKE_MASK 16'h019d
`define DSH_DIR_RST 16'hffff
`define DSH_LAT_RST 16'h0000
`define DSH_ARM_WINDOW 2'h3
`define DSH_WDT_BASE 5
`endif

/* File: rtl/dsh_pkg.sv */
// Types shared by the deep sleep hold block
package dsh_pkg;
	typedef enum logic [1:0] {
		DSH_RUN,
		DSH_SLEEP,
		DSH_WAKE
	} dsh_state_t;
	typedef struct packed {
		logic [15:0] dir;
		logic [15:0] lat;
	} dsh_pins_t;
	typedef struct packed {
		logic master_clear_pin;
		logic brownout;
		logic rtc_alarm;
		logic ext_int_zero;
		logic fault;
	} dsh_events_t;
endpackage

/* File: rtl/dsh_sleep_ctrl.sv */
// Deep sleep pin hold, retention, sleep watchdog and status, APB slave
//
// Contract
// - Input-configured pins stay high-impedance until freeze flag is cleared.
// - Output pins keep driving the latch level captured at sleep entry.
// - Wake resets direction, latch and oscillator enable; pins stay frozen unless brown-out woke.
// - Writes do not reach pins while frozen; clearing applies programmed values.
// - Oscillator keeps running in sleep; set enable before clearing freeze.
// - Enabled brown-out in sleep releases pins and loses all retained state.
// - Master clear in sleep keeps scratch, control, wake; pins go to reset.
// - Oscillator enable changes wait for freeze flag to clear.
// - Config bit 7 enables sleep watchdog regardless of main watchdog.
// - Each sleep entry resets the sleep watchdog counter.
// - Config bit 4 selects watchdog clock, bits 3:0 its postscaler.
// - Calendar and watchdog run from either oscillator; config bit 5 selects calendar.
// - An enabled watchdog turns its stopped clock source on at entry.
// - Sleep entry sets exit flag, bit 10 of reset control; software clears.
// - True power-on reset clears the deep sleep registers and watchdog, but sets the power-on flag and direction bits.
// - Arm bit 15 clears automatically on sleep exit.
// - Arm bit clears if power-save does not follow within four cycles.
// - Setting the arm bit clears the whole wake-source register.
// - Wake events before power-on sequence completes are not recorded.
`include "dsh_defines.svh"

module dsh_sleep_ctrl #(
	parameter int WDT_W = 32
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [7:0] config_word_four_in,
	input wire logic pwrsav_sleep_in,
	input wire dsh_pkg::dsh_events_t events_in,
	input wire logic por_done_in,
	input wire logic secondary_osc_tick_in,
	input wire logic low_power_rc_osc_tick_in,
	output logic [15:0] pin_level_out,
	output logic [15:0] pin_oe_out,
	output logic secondary_osc_on_out,
	output logic low_power_rc_on_out,
	output logic rtc_tick_out,
	output logic sleeping_out
);
	import dsh_pkg::*;

	// ---------------------------------------------------------------
	// Parameter check: counter must hold the largest postscaled limit
	// ---------------------------------------------------------------
	if (WDT_W < `DSH_WDT_BASE + 16 || WDT_W > 32) begin : g_wdt_w_check
		$error("WDT_W must hold the largest postscaled count");
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	function automatic logic addr_ok(input logic [7:0] a);
		case (a)
			`DSH_OFF_CTRL, `DSH_OFF_RST, `DSH_OFF_SCR0, `DSH_OFF_SCR1, `DSH_OFF_WAKE,
			`DSH_OFF_DIR, `DSH_OFF_LAT, `DSH_OFF_OSC, `DSH_OFF_STAT: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	endfunction

	logic wr_en, rd_setup;
	assign wr_en = psel_in & penable_in & pwrite_in & addr_ok(paddr_in);
	assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
	assign pready_out = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~addr_ok(paddr_in);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	dsh_state_t state_q, state_d;
	dsh_pins_t hold_q, hold_d, regs_q, regs_d, pins_q, pins_d;
	logic arm_q, arm_d, bor_q, bor_d, freeze_q, freeze_d;
	logic exit_q, exit_d, porf_q, porf_d;
	logic [1:0] arm_cnt_q, arm_cnt_d;
	logic [15:0] scr0_q, scr0_d, scr1_q, scr1_d, wake_q, wake_d;
	logic secondary_osc_en_q, secondary_osc_en_d, secondary_osc_run_q, secondary_osc_run_d;
	logic [WDT_W-1:0] wdt_cnt_q, wdt_cnt_d;
	logic [31:0] rdata_q, rdata_d;

	logic wdt_en, wdt_tick, wdt_limit_hit;
	logic [WDT_W-1:0] wdt_limit;
	assign wdt_en = config_word_four_in[`DSH_CW4_WDT_EN];
	assign wdt_tick = config_word_four_in[`DSH_CW4_WDT_SEL] ? low_power_rc_osc_tick_in : secondary_osc_tick_in;
	assign wdt_limit = WDT_W'(({{(WDT_W-1){1'b0}}, 1'b1} << (`DSH_WDT_BASE + config_word_four_in[3:0])) - 1);
	assign wdt_limit_hit = wdt_cnt_q == wdt_limit;

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		regs_d = regs_q;
		arm_d = arm_q;
		arm_cnt_d = arm_cnt_q;
		bor_d = bor_q;
		freeze_d = freeze_q;
		exit_d = exit_q;
		porf_d = porf_q;
		scr0_d = scr0_q;
		scr1_d = scr1_q;
		wake_d = wake_q;
		secondary_osc_en_d = secondary_osc_en_q;
		wdt_cnt_d = wdt_cnt_q;
		rdata_d = rdata_q;

		// Software writes, taken in the access phase
		if (wr_en) begin
			case (paddr_in)
				`DSH_OFF_CTRL: begin
					if (pwdata_in[`DSH_CTRL_ARM]) begin
						arm_d = 1'b1;
						arm_cnt_d = 2'h0;
						wake_d = 16'h0000;
					end else begin
						arm_d = 1'b0;
					end
					bor_d = pwdata_in[`DSH_CTRL_BOR];
					if (!pwdata_in[`DSH_CTRL_FREEZE]) begin
						freeze_d = 1'b0;
					end
				end
				`DSH_OFF_RST: begin
					exit_d = exit_q & pwdata_in[`DSH_RST_EXIT];
					porf_d = porf_q & pwdata_in[`DSH_RST_POR];
				end
				`DSH_OFF_SCR0: scr0_d = pwdata_in[15:0];
				`DSH_OFF_SCR1: scr1_d = pwdata_in[15:0];
				`DSH_OFF_WAKE: if (!arm_q) wake_d = pwdata_in[15:0] & `DSH_WAKE_MASK;
				`DSH_OFF_DIR: regs_d.dir = pwdata_in[15:0];
				`DSH_OFF_LAT: regs_d.lat = pwdata_in[15:0];
				`DSH_OFF_OSC: secondary_osc_en_d = pwdata_in[`DSH_OSC_SECONDARY_OSC_EN];
				default: ;
			endcase
		end

		case (state_q)
			DSH_RUN: begin
				if (arm_q && pwrsav_sleep_in) begin
					state_d = DSH_SLEEP;
					hold_d = pins_q;
					freeze_d = 1'b1;
					// exit flag set on entry, set wins
					exit_d = 1'b1;
					wdt_cnt_d = '0;
				end else if (arm_q) begin
					if (arm_cnt_q == `DSH_ARM_WINDOW) begin
						arm_d = 1'b0;
					end else begin
						arm_cnt_d = arm_cnt_q + 2'h1;
					end
				end
			end
			DSH_SLEEP: begin
				if (wdt_en && wdt_tick && !wdt_limit_hit) begin
					wdt_cnt_d = wdt_cnt_q + WDT_W'(1);
				end
				// Brownout outranks master clear, which outranks the rest
				if (events_in.brownout && config_word_four_in[`DSH_CW4_BOR_EN]) begin
					// release at once, drop retained state
					state_d = DSH_WAKE;
					freeze_d = 1'b0;
					scr0_d = 16'h0000;
					scr1_d = 16'h0000;
					bor_d = 1'b1;
					porf_d = 1'b1;
					wake_d = 16'h0001 << `DSH_WAKE_POR;
				end else if (events_in.master_clear_pin) begin
					// keep scratch and control, pins to reset state
					state_d = DSH_WAKE;
					hold_d.dir = `DSH_DIR_RST;
					hold_d.lat = `DSH_LAT_RST;
					wake_d[`DSH_WAKE_MASTER_CLEAR_PIN] = 1'b1;
				end else if ((wdt_en && wdt_limit_hit) || events_in.rtc_alarm || events_in.ext_int_zero) begin
					state_d = DSH_WAKE;
					wake_d[`DSH_WAKE_WDT] = wdt_en && wdt_limit_hit;
					wake_d[`DSH_WAKE_RTC] = events_in.rtc_alarm;
					wake_d[`DSH_WAKE_EXTERNAL_INT_ZERO] = events_in.ext_int_zero;
				end
				wake_d[`DSH_WAKE_FLT] = wake_q[`DSH_WAKE_FLT] | events_in.fault;
				if (state_d == DSH_WAKE) begin
					arm_d = 1'b0;
					regs_d.dir = `DSH_DIR_RST;
					regs_d.lat = `DSH_LAT_RST;
					secondary_osc_en_d = 1'b0;
				end
			end
			DSH_WAKE: begin
				// Freeze flag untouched: pins stay held until software lets go
				// events ignored until sequence completes
				if (por_done_in) begin
					state_d = DSH_RUN;
				end
			end
			default: state_d = DSH_RUN;
		endcase

		// pins follow registers only when unfrozen
		pins_d = freeze_d ? hold_d : regs_d;
		secondary_osc_run_d = freeze_d ? secondary_osc_run_q : secondary_osc_en_d;

		if (rd_setup) begin
			case (paddr_in)
				`DSH_OFF_CTRL: rdata_d = 32'(({arm_q, 15'h0000} | {14'h0000, bor_q, freeze_q}));
				`DSH_OFF_RST: rdata_d = 32'((16'(exit_q) << `DSH_RST_EXIT) | 16'(porf_q));
				`DSH_OFF_SCR0: rdata_d = {16'h0000, scr0_q};
				`DSH_OFF_SCR1: rdata_d = {16'h0000, scr1_q};
				`DSH_OFF_WAKE: rdata_d = {16'h0000, wake_q};
				`DSH_OFF_DIR: rdata_d = {16'h0000, regs_q.dir};
				`DSH_OFF_LAT: rdata_d = {16'h0000, regs_q.lat};
				`DSH_OFF_OSC: rdata_d = 32'(16'(secondary_osc_en_q) << `DSH_OSC_SECONDARY_OSC_EN);
				`DSH_OFF_STAT: rdata_d = {28'h0000000, secondary_osc_run_q, state_q == DSH_WAKE, state_q == DSH_SLEEP, wdt_limit_hit};
				default: rdata_d = 32'h00000000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers, cleared only by a true power-on reset
	// ---------------------------------------------------------------
	// power-on reset clears everything but the power-on flag and direction bits, which it sets
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_q <= DSH_RUN;
			hold_q <= {`DSH_DIR_RST, `DSH_LAT_RST};
			regs_q <= {`DSH_DIR_RST, `DSH_LAT_RST};
			pins_q <= {`DSH_DIR_RST, `DSH_LAT_RST};
			arm_q <= 1'b0;
			arm_cnt_q <= 2'h0;
			bor_q <= 1'b0;
			freeze_q <= 1'b0;
			exit_q <= 1'b0;
			porf_q <= 1'b1;
			scr0_q <= 16'h0000;
			scr1_q <= 16'h0000;
			wake_q <= 16'h0000;
			secondary_osc_en_q <= 1'b0;
			secondary_osc_run_q <= 1'b0;
			wdt_cnt_q <= '0;
			rdata_q <= 32'h00000000;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			regs_q <= regs_d;
			pins_q <= pins_d;
			arm_q <= arm_d;
			arm_cnt_q <= arm_cnt_d;
			bor_q <= bor_d;
			freeze_q <= freeze_d;
			exit_q <= exit_d;
			porf_q <= porf_d;
			scr0_q <= scr0_d;
			scr1_q <= scr1_d;
			wake_q <= wake_d;
			secondary_osc_en_q <= secondary_osc_en_d;
			secondary_osc_run_q <= secondary_osc_run_d;
			wdt_cnt_q <= wdt_cnt_d;
			rdata_q <= rdata_d;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata_out = rdata_q;
	assign pin_level_out = pins_q.lat;
	assign pin_oe_out = ~pins_q.dir;
	// watchdog source forced on in sleep
	assign secondary_osc_on_out = secondary_osc_run_q | (sleeping_out & wdt_en & ~config_word_four_in[`DSH_CW4_WDT_SEL]);
	assign low_power_rc_on_out = sleeping_out & wdt_en & config_word_four_in[`DSH_CW4_WDT_SEL];
	assign rtc_tick_out = config_word_four_in[`DSH_CW4_RTC_SEL] ? low_power_rc_osc_tick_in : secondary_osc_tick_in;
	assign sleeping_out = state_q == DSH_SLEEP;
endmodule

/* File: tb/dsh_sleep_ctrl_props.sv */
// Port checker for the deep sleep hold block
`include "dsh_defines.svh"
module dsh_props
	import dsh_pkg::*;
	#(parameter int WDT_W = 32) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [7:0] config_word_four_in,
	input wire logic pwrsav_sleep_in,
	input wire dsh_pkg::dsh_events_t events_in,
	input wire logic por_done_in,
	input wire logic secondary_osc_tick_in,
	input wire logic low_power_rc_osc_tick_in,
	input wire logic [15:0] pin_level_out,
	input wire logic [15:0] pin_oe_out,
	input wire logic secondary_osc_on_out,
	input wire logic low_power_rc_on_out,
	input wire logic rtc_tick_out,
	input wire logic sleeping_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	sequence arm_set;
		psel_in && penable_in && pwrite_in && paddr_in == `DSH_OFF_CTRL && pwdata_in[`DSH_CTRL_ARM];
	endsequence
	sequence quiet;
		!pwrsav_sleep_in && !(psel_in && penable_in && pwrite_in);
	endsequence
	pins_hold_a: assert property (sleeping_out [*3] |-> $stable(pin_oe_out) && $stable(pin_level_out))
		else $error("pins moved in sleep");
	arm_entry_a: assert property (arm_set ##1 (pwrsav_sleep_in && !sleeping_out) |=> sleeping_out)
		else $error("armed entry missed");
	arm_expire_a: assert property (arm_set ##1 quiet [*4] ##1 pwrsav_sleep_in |=> !sleeping_out)
		else $error("stale arm entered sleep");
	wake_exit_a: assert property (sleeping_out && (events_in.rtc_alarm || events_in.master_clear_pin) |=> !sleeping_out)
		else $error("no wake on event");
	master_clear_pin_pins_a: assert property (sleeping_out && events_in.master_clear_pin |-> ##[1:3] pin_oe_out == 16'h0000)
		else $error("pins not reset on master_clear_pin");
	bor_release_a: assert property (sleeping_out && events_in.brownout && config_word_four_in[`DSH_CW4_BOR_EN]
		|-> ##[1:3] pin_oe_out == 16'h0000) else $error("pins not released on brownout");
	rtc_source_a: assert property (rtc_tick_out == (config_word_four_in[`DSH_CW4_RTC_SEL] ? low_power_rc_osc_tick_in : secondary_osc_tick_in))
		else $error("wrong rtc source");
	wdt_clock_a: assert property (sleeping_out ##1 (sleeping_out && config_word_four_in[`DSH_CW4_WDT_EN])
		|-> (config_word_four_in[`DSH_CW4_WDT_SEL] ? low_power_rc_on_out : secondary_osc_on_out))
		else $error("watchdog clock off");
	bad_addr_a: assert property (psel_in && penable_in && paddr_in[1:0] == 2'h0 |-> pslverr_out == (paddr_in > `DSH_OFF_STAT))
		else $error("wrong slave error");
endmodule
bind dsh_sleep_ctrl dsh_props #(.WDT_W(WDT_W)) u_props (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.config_word_four_in(config_word_four_in), .pwrsav_sleep_in(pwrsav_sleep_in), .events_in(events_in),
	.por_done_in(por_done_in), .secondary_osc_tick_in(secondary_osc_tick_in), .low_power_rc_osc_tick_in(low_power_rc_osc_tick_in),
	.pin_level_out(pin_level_out), .pin_oe_out(pin_oe_out), .secondary_osc_on_out(secondary_osc_on_out),
	.low_power_rc_on_out(low_power_rc_on_out), .rtc_tick_out(rtc_tick_out), .sleeping_out(sleeping_out));

/* File: tb/tb_top.sv */
// Register level testbench of the deep sleep hold block
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import dsh_pkg::*;
	logic mclk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pwrsav = 1'b0, por_done = 1'b1, low_power_rc_osc = 1'b0, secondary_osc = 1'b0;
	logic [1:0] tick_div = 2'h0;
	logic [7:0] paddr = 8'h00, cfg = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, secondary_osc_on, low_power_rc_osc_on, rtc_tick, sleeping;
	logic [15:0] pin_level, pin_oe;
	dsh_events_t ev = '0;
	int err_count = 0;
	int cmp_count = 0;
	int slept = 0;
	int t0 = 0;
	always #20 mclk = ~mclk;
	// Slow oscillator ticks: every second and every fourth cycle
	always @(posedge mclk) begin
		low_power_rc_osc <= ~low_power_rc_osc;
		tick_div <= tick_div + 2'h1;
		secondary_osc <= tick_div == 2'h3;
		if (sleeping === 1'b1) begin
			slept <= slept + 1;
		end
	end
	dsh_sleep_ctrl dut (.mclk_in(mclk), .arst_n_in(arst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .config_word_four_in(cfg), .pwrsav_sleep_in(pwrsav), .events_in(ev),
		.por_done_in(por_done), .secondary_osc_tick_in(secondary_osc), .low_power_rc_osc_tick_in(low_power_rc_osc), .pin_level_out(pin_level),
		.pin_oe_out(pin_oe), .secondary_osc_on_out(secondary_osc_on), .low_power_rc_on_out(low_power_rc_osc_on),
		.rtc_tick_out(rtc_tick), .sleeping_out(sleeping));
	task close_out;
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		cmp(rd, exp);
	endtask
	// Pin registers load on the same edge as the control registers
	task pins(input logic [15:0] oe, input logic [15:0] lvl);
		repeat (3) @(negedge mclk);
		cmp({pin_oe, pin_level & pin_oe}, {oe, lvl & oe});
	endtask
	task sleep(input dsh_events_t e);
		wr(8'h00, 32'h8000);
		pwrsav <= 1'b1;
		por_done <= 1'b0;
		@(posedge mclk);
		pwrsav <= 1'b0;
		@(negedge mclk);
		cmp(sleeping, 1'b1);
		@(posedge mclk);
		ev <= e;
		wait (sleeping === 1'b0);
		@(posedge mclk);
		ev <= 5'b00010;
		@(posedge mclk);
		ev <= '0;
		por_done <= 1'b1;
		repeat (2) @(posedge mclk);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		arst_n <= 1'b1;
		rdchk(8'h04, 32'h1);
		rdchk(8'h14, 32'hffff);
		rdchk(8'h24, 32'h0);
		wr(8'h08, 32'h1234);
		wr(8'h14, 32'hfff0);
		wr(8'h18, 32'h000a);
		pins(16'h000f, 16'h000a);
		sleep(5'b00100);
		rdchk(8'h00, 32'h1);
		rdchk(8'h04, 32'h401);
		rdchk(8'h10, 32'h8);
		rdchk(8'h14, 32'hffff);
		rdchk(8'h08, 32'h1234);
		wr(8'h14, 32'h0);
		wr(8'h18, 32'hffff);
		pins(16'h000f, 16'h000a);
		wr(8'h00, 32'h0);
		pins(16'hffff, 16'hffff);
		wr(8'h04, 32'h0);
		rdchk(8'h04, 32'h0);
		wr(8'h00, 32'h8000);
		repeat (4) @(posedge mclk);
		pwrsav <= 1'b1;
		@(posedge mclk);
		pwrsav <= 1'b0;
		@(negedge mclk);
		cmp(sleeping, 1'b0);
		wr(8'h0c, 32'hbeef);
		sleep(5'b10000);
		pins(16'h0, 16'h0);
		rdchk(8'h0c, 32'hbeef);
		rdchk(8'h10, 32'h4);
		rdchk(8'h00, 32'h1);
		wr(8'h1c, 32'h2);
		@(negedge mclk);
		cmp(secondary_osc_on, 1'b0);
		wr(8'h00, 32'h0);
		@(negedge mclk);
		cmp(secondary_osc_on, 1'b1);
		cfg <= 8'h40;
		sleep(5'b01000);
		rdchk(8'h00, 32'h2);
		rdchk(8'h0c, 32'h0);
		rdchk(8'h10, 32'h1);
		cfg <= 8'hb0;
		sleep(5'b00000);
		rdchk(8'h10, 32'h10);
		cfg <= 8'h80;
		t0 = slept;
		sleep(5'b00000);
		cmp((slept - t0 >= 120 && slept - t0 <= 127) ? 32'h1 : 32'h0, 32'h1);
		rdchk(8'h10, 32'h10);
		wr(8'h00, 32'h8000);
		rdchk(8'h10, 32'h0);
		close_out;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		err_count++;
		close_out;
	end
endmodule
